// ===== inc/spot_regs.svh
// Register indices, field positions, reset values and timing counts
// for the self polling on-time block. Definitions only.
`ifndef SPOT_REGS_SVH
`define SPOT_REGS_SVH

// Register byte addresses; each register answers on data lane 0, except COUNT, which reads on lanes 0 and 1
`define SPOT_IDX_A_LOW    10'h09c
`define SPOT_IDX_A_HIGH   10'h09d
`define SPOT_IDX_B_LOW    10'h09e
`define SPOT_IDX_B_HIGH   10'h09f
`define SPOT_IDX_C_LOW    10'h0a0
`define SPOT_IDX_C_HIGH   10'h0a1
`define SPOT_IDX_D_LOW    10'h0a2
`define SPOT_IDX_D_HIGH   10'h0a3
`define SPOT_IDX_CTRL     10'h0b0
`define SPOT_IDX_DIVISOR  10'h0b1
`define SPOT_IDX_STATUS   10'h0b2
`define SPOT_IDX_COUNT    10'h0b3

// Reset values
`define SPOT_RST_LOW      8'h01
`define SPOT_RST_HIGH     6'h00
`define SPOT_RST_DIVISOR  8'h01
`define SPOT_RST_SELECT   2'h0

// Field positions
`define SPOT_HIGH_MSB     5
`define SPOT_CTRL_RUN     0
`define SPOT_CTRL_SEL_LSB 2
`define SPOT_CTRL_SEL_MSB 3
`define SPOT_STAT_ACTIVE  0
`define SPOT_STAT_CFG_LSB 1
`define SPOT_STAT_CFG_MSB 2

// Timing: system cycles per prescaler period, max on-time periods
`define SPOT_PRESCALE     64
`define SPOT_MAX_PERIODS  15'h4000

`endif

// ===== inc/spot_pkg.sv
// Types shared by the self polling on-time block.
// Assumes the constants of spot_regs.svh are included where needed.
package spot_pkg;

  typedef logic [13:0] spot_value_t;
  typedef logic [14:0] spot_count_t;

  typedef enum logic [1:0] {
    SPOT_CFG_A = 2'b00,
    SPOT_CFG_B = 2'b01,
    SPOT_CFG_C = 2'b10,
    SPOT_CFG_D = 2'b11
  } spot_cfg_e;

  typedef enum logic [0:0] {
    SPOT_ST_IDLE = 1'b0,
    SPOT_ST_ON   = 1'b1
  } spot_state_e;

endpackage

// ===== inc/spot_tick_if.sv
// Link between the on-time counter and its reference timer.
// Assumes both ends share one system clock.
`timescale 1ns/100ps

interface spot_tick_if;
  logic       clr;
  logic [7:0] divisor;
  logic       tick;

  modport timer (input clr, input divisor, output tick);
  modport user  (output clr, output divisor, input tick);
endinterface

// ===== verilog/spot_ref_timer.sv
// Reference timer: one tick every prescale times divisor system cycles.
// Assumes clr is held by the user whenever no on phase runs.
`timescale 1ns/100ps
`include "spot_regs.svh"

module spot_ref_timer #(
  parameter int PRESCALE = `SPOT_PRESCALE
) (
  input  wire logic   i_clk,
  input  wire logic   i_rst,
  spot_tick_if.timer  tick_if
);

  localparam int PW = $clog2(PRESCALE);

  if (PRESCALE < 2 || (1 << PW) != PRESCALE) begin : g_chk
    $error("PRESCALE must be a power of two, at least 2");
  end

  logic [PW-1:0] pre_ff;
  logic [7:0]    div_ff;
  logic          tick_ff;
  logic          pre_wrap;
  logic          div_wrap;

  assign pre_wrap = (pre_ff == PW'(PRESCALE - 1));
  // Divisor 0 wraps at 255, giving 256 periods
  assign div_wrap = (div_ff == (tick_if.divisor - 8'h01));

  always_ff @(posedge i_clk) begin
    if (i_rst || tick_if.clr) begin
      pre_ff <= '0;
    end else begin
      pre_ff <= pre_ff + PW'(1);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || tick_if.clr) begin
      div_ff <= 8'h00;
    end else if (pre_wrap) begin
      div_ff <= div_wrap ? 8'h00 : div_ff + 8'h01;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst || tick_if.clr) begin
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= pre_wrap && div_wrap; // RULE_07
    end
  end

  assign tick_if.tick = tick_ff;

endmodule

// ===== verilog/spot_top.sv
// Self polling on-time set values and on-time counter, Wishbone slave.
// Assumes a sequencer pulses I_ON_START to open each on phase.
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/100ps
`include "spot_regs.svh"

// Contract
// RULE_01: Each configuration value is high six bits over low eight bits.
// RULE_02: On phase lasts set value times reference timer periods.
// RULE_03: Value 1 gives one period, 3FFFh gives 16383, linear between.
// RULE_04: Value zero gives the longest on-time, 16384 periods.
// RULE_05: After reset low registers read 01h, high registers 00h.
// RULE_06: Four independent pairs, lower byte first, byte addresses 09C to 0A3.
// RULE_07: Reference period is 64 system cycles times divisor register.
// RULE_08: Two-bit select: A, A+B, A to C, or all four configurations.
// RULE_09: Counter loads current value at phase start, ends at terminal.
module spot_top #(
  parameter int PRESCALE = `SPOT_PRESCALE,
  parameter int ADR_W    = 12
) (
  input  wire logic              I_SYS_CLK,
  input  wire logic              I_RST,
  input  wire logic              I_WB_CYC,
  input  wire logic              I_WB_STB,
  input  wire logic              I_WB_WE,
  input  wire logic [ADR_W-1:0]  I_WB_ADR,
  input  wire logic [3:0]        I_WB_SEL,
  input  wire logic [31:0]       I_WB_DAT,
  input  wire logic              I_ON_START,
  output logic                   O_WB_ACK,
  output logic [31:0]            O_WB_DAT,
  output logic                   O_ON_ACTIVE,
  output logic                   O_ON_DONE,
  output logic [1:0]             O_CFG_SEL
);

  if (ADR_W < 11) begin : g_chk
    $error("ADR_W must exceed the ten register address bits");
  end

  // Register storage
  logic [7:0]               low_ff [4];
  logic [5:0]               high_ff [4];
  logic                     run_ff;
  logic [1:0]               select_ff;
  logic [7:0]               divisor_ff;

  // Counter state
  spot_pkg::spot_state_e    state_ff;
  spot_pkg::spot_state_e    nxt_state;
  spot_pkg::spot_cfg_e      cfg_ff;
  spot_pkg::spot_count_t    count_ff;
  logic                     done_ff;
  logic                     active_ff;

  // Bus state
  logic                     ack_ff;
  logic [31:0]              rdata_ff;
  logic [9:0]               idx;
  logic                     req;
  logic                     wr_en;
  logic                     start_ok;
  logic                     phase_end;

  spot_tick_if              tick_if ();

  // 14-bit value of one configuration
  function automatic spot_pkg::spot_value_t value_of(input logic [7:0] lo,
      input logic [5:0] hi);
    value_of = {hi, lo}; // RULE_01
  endfunction

  // Periods to count for a set value; zero stands for the maximum
  function automatic spot_pkg::spot_count_t periods_of(
      input spot_pkg::spot_value_t v);
    if (v == 14'h0000) begin
      periods_of = `SPOT_MAX_PERIODS; // RULE_04
    end else begin
      periods_of = {1'b0, v}; // RULE_03
    end
  endfunction

  // Configuration that follows c for a select code; back to A after the last one taking part
  function automatic spot_pkg::spot_cfg_e next_cfg(
      input spot_pkg::spot_cfg_e c, input logic [1:0] sel);
    if (c >= spot_pkg::spot_cfg_e'(sel)) begin
      next_cfg = spot_pkg::SPOT_CFG_A; // RULE_08
    end else begin
      next_cfg = spot_pkg::spot_cfg_e'(c + 2'b01); // RULE_08
    end
  endfunction

  // Index of a pair register: bit 0 picks high, the rest the config
  function automatic logic pair_hit(input logic [9:0] i);
    pair_hit = (i >= `SPOT_IDX_A_LOW) && (i <= `SPOT_IDX_D_HIGH); // RULE_06
  endfunction

  function automatic logic [1:0] pair_cfg(input logic [9:0] i);
    logic [9:0] d;
    d = i - `SPOT_IDX_A_LOW;
    pair_cfg = d[2:1];
  endfunction

  // Bus decode
  // Byte addresses above the map fold onto an unused index
  assign idx   = (I_WB_ADR[ADR_W-1:10] == '0) ? I_WB_ADR[9:0] : 10'h3ff;
  assign req   = I_WB_CYC && I_WB_STB && !ack_ff;
  assign wr_en = req && I_WB_WE && I_WB_SEL[0];

  // One wait-free cycle: ack follows the request edge, drops after
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= req;
    end
  end

  // Low value registers
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      for (int k = 0; k < 4; k++) begin
        low_ff[k] <= `SPOT_RST_LOW; // RULE_05
      end
    end else if (wr_en && pair_hit(idx) && !idx[0]) begin
      low_ff[pair_cfg(idx)] <= I_WB_DAT[7:0]; // RULE_06
    end
  end

  // High value registers, six bits wide
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      for (int k = 0; k < 4; k++) begin
        high_ff[k] <= `SPOT_RST_HIGH; // RULE_05
      end
    end else if (wr_en && pair_hit(idx) && idx[0]) begin
      high_ff[pair_cfg(idx)] <= I_WB_DAT[`SPOT_HIGH_MSB:0]; // RULE_01
    end
  end

  // Control register
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      run_ff    <= 1'b0;
      select_ff <= `SPOT_RST_SELECT;
    end else if (wr_en && idx == `SPOT_IDX_CTRL) begin
      run_ff    <= I_WB_DAT[`SPOT_CTRL_RUN];
      select_ff <= I_WB_DAT[`SPOT_CTRL_SEL_MSB:`SPOT_CTRL_SEL_LSB];
    end
  end

  // Reference timer divisor
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      divisor_ff <= `SPOT_RST_DIVISOR;
    end else if (wr_en && idx == `SPOT_IDX_DIVISOR) begin
      divisor_ff <= I_WB_DAT[7:0]; // RULE_07
    end
  end

  // Read data; unmapped indices read as zero and are still acked
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      rdata_ff <= 32'h0000_0000;
    end else if (req && !I_WB_WE) begin
      if (pair_hit(idx) && !idx[0]) begin
        rdata_ff <= {24'h00_0000, low_ff[pair_cfg(idx)]};
      end else if (pair_hit(idx)) begin
        rdata_ff <= {26'h000_0000, high_ff[pair_cfg(idx)]};
      end else if (idx == `SPOT_IDX_CTRL) begin
        rdata_ff <= {28'h000_0000, select_ff, 1'b0, run_ff};
      end else if (idx == `SPOT_IDX_DIVISOR) begin
        rdata_ff <= {24'h00_0000, divisor_ff};
      end else if (idx == `SPOT_IDX_STATUS) begin
        rdata_ff <= {29'h0000_0000, cfg_ff, state_ff == spot_pkg::SPOT_ST_ON};
      end else if (idx == `SPOT_IDX_COUNT) begin
        rdata_ff <= {17'h0_0000, count_ff};
      end else begin
        rdata_ff <= 32'h0000_0000;
      end
    end
  end

  // Sequencing
  assign start_ok  = run_ff && I_ON_START;
  assign phase_end = (state_ff == spot_pkg::SPOT_ST_ON) && tick_if.tick
                     && (count_ff == 15'h0001);

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      spot_pkg::SPOT_ST_IDLE: begin
        if (start_ok) begin
          nxt_state = spot_pkg::SPOT_ST_ON;
        end
      end
      spot_pkg::SPOT_ST_ON: begin
        if (!run_ff || phase_end) begin
          nxt_state = spot_pkg::SPOT_ST_IDLE; // RULE_09
        end
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      state_ff <= spot_pkg::SPOT_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Phase counter: load at start, one step per reference tick
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      count_ff <= 15'h0000;
    end else if (state_ff == spot_pkg::SPOT_ST_IDLE && start_ok) begin
      count_ff <= periods_of(value_of(low_ff[cfg_ff],
                                      high_ff[cfg_ff])); // RULE_09
    end else if (state_ff == spot_pkg::SPOT_ST_ON && tick_if.tick) begin
      count_ff <= count_ff - 15'h0001; // RULE_02
    end
  end

  // Current configuration; moves on after each finished phase
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      cfg_ff <= spot_pkg::SPOT_CFG_A;
    end else if (!run_ff) begin
      cfg_ff <= spot_pkg::SPOT_CFG_A;
    end else if (phase_end) begin
      cfg_ff <= next_cfg(cfg_ff, select_ff); // RULE_08
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      done_ff <= 1'b0;
    end else begin
      done_ff <= phase_end; // RULE_02
    end
  end

  // Registered twin of the state so the port comes from a flip-flop
  always_ff @(posedge I_SYS_CLK) begin
    if (I_RST) begin
      active_ff <= 1'b0;
    end else begin
      active_ff <= nxt_state == spot_pkg::SPOT_ST_ON; // RULE_02
    end
  end

  // Timer restarts with each phase so the first period is whole
  assign tick_if.clr     = (state_ff != spot_pkg::SPOT_ST_ON);
  assign tick_if.divisor = divisor_ff;

  spot_ref_timer #(
    .PRESCALE (PRESCALE)
  ) u_ref_timer (
    .i_clk    (I_SYS_CLK),
    .i_rst    (I_RST),
    .tick_if  (tick_if)
  );

  // Outputs straight from flip-flops
  assign O_WB_ACK    = ack_ff;
  assign O_WB_DAT    = rdata_ff;
  assign O_ON_ACTIVE = active_ff;
  assign O_ON_DONE   = done_ff;
  assign O_CFG_SEL   = cfg_ff;

endmodule

// ===== test/spot_top_chk.sv
// Port checker for the on-time block.
// Assumes it is bound onto spot_top; one clock domain.
`timescale 1ns/100ps

module spot_top_chk #(
  parameter int PRESCALE = 64,
  parameter int ADR_W    = 12
) (
  input wire logic              I_SYS_CLK,
  input wire logic              I_RST,
  input wire logic              I_WB_CYC,
  input wire logic              I_WB_STB,
  input wire logic              I_ON_START,
  input wire logic              O_WB_ACK,
  input wire logic [31:0]       O_WB_DAT,
  input wire logic              O_ON_ACTIVE,
  input wire logic              O_ON_DONE,
  input wire logic [1:0]        O_CFG_SEL
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  default disable iff (I_RST);

  ack_pulse_a: assert property (O_WB_ACK |=> !O_WB_ACK)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (I_WB_CYC && I_WB_STB && !O_WB_ACK
    |=> O_WB_ACK) else $error("request not acked next cycle");
  dat_upper_a: assert property (O_WB_ACK |-> O_WB_DAT[31:15] == 17'h0)
    else $error("read data upper bits set");
  done_after_a: assert property (
    O_ON_DONE |-> !O_ON_ACTIVE && $past(O_ON_ACTIVE))
    else $error("done without phase end");
  done_pulse_a: assert property (O_ON_DONE |=> !O_ON_DONE)
    else $error("done longer than one cycle");
  active_cause_a: assert property (
    $rose(O_ON_ACTIVE) |-> $past(I_ON_START))
    else $error("phase opened without start");
  cfg_hold_a: assert property (
    O_ON_ACTIVE && $past(O_ON_ACTIVE) |-> $stable(O_CFG_SEL))
    else $error("config changed inside phase");
  cfg_step_a: assert property (
    O_ON_DONE |-> O_CFG_SEL == 2'($past(O_CFG_SEL) + 2'h1)
      || O_CFG_SEL == 2'h0) else $error("config did not advance");
  reset_quiet_a: assert property (disable iff (1'b0)
    I_RST |=> !O_WB_ACK && !O_ON_ACTIVE && !O_ON_DONE && O_CFG_SEL == 2'h0)
    else $error("outputs not quiet after reset");

  cover property ($rose(O_ON_ACTIVE));
  cover property (O_ON_DONE && O_CFG_SEL == 2'h3);
  cover property (O_WB_ACK && !O_ON_ACTIVE);
endmodule

// ===== test/spot_top_tb.sv
// Self-checking bench for the on-time block.
// Assumes a shortened prescaler; drives Wishbone and start itself.
`timescale 1ns/100ps
`include "spot_regs.svh"
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end

module spot_top_tb;
  localparam int P = 4;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, start = 1'b0;
  logic [11:0] adr = 12'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, act, done;
  logic [1:0]  cfg;
  int          err_count = 0, n_compared = 0;
  int          len[4] = '{257, 2, 3, 4};

  always #20 clk = ~clk;

  spot_top #(.PRESCALE(P)) dut (.I_SYS_CLK(clk), .I_RST(rst),
    .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(sel), .I_WB_DAT(wdat), .I_ON_START(start), .O_WB_ACK(ack),
    .O_WB_DAT(rdat), .O_ON_ACTIVE(act), .O_ON_DONE(done), .O_CFG_SEL(cfg));

  task automatic summarize;
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic wb(input logic w, input logic [9:0] idx,
                    input logic [7:0] d, input logic [3:0] s);
    int i;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {2'b00, idx};
    sel <= s;
    wdat <= {24'h0, d};
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ack !== 1'b1 && i < 50);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i >= 50) begin
      err_count++;
      summarize();
    end
  endtask

  task automatic wr(input logic [9:0] idx, input logic [7:0] d);
    wb(1'b1, idx, d, 4'h1);
  endtask

  task automatic rd_chk(input logic [9:0] idx, input logic [7:0] e);
    wb(1'b0, idx, 8'h00, 4'hf);
    `CHK(q, {24'h0, e})
  endtask

  // Counts cycles with the phase open; one cycle of slack on the end
  task automatic phase(input int exp);
    int n;
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (act === 1'b1 && n < 70000);
    `CHK(done, 1'b1)
    `CHK(n - 1 >= exp && n - 1 <= exp + 1, 1'b1)
    if (n >= 70000) begin
      summarize();
    end
  endtask

  task automatic t_regs;
    for (int i = 0; i < 8; i++) begin
      rd_chk(10'(`SPOT_IDX_A_LOW + i), i[0] ? 8'h00 : 8'h01);
    end
    rd_chk(10'h0c0, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(10'(`SPOT_IDX_A_LOW + 2 * i), 8'(8'ha0 + i));
      wr(10'(`SPOT_IDX_A_HIGH + 2 * i), 8'hff);
    end
    wb(1'b1, `SPOT_IDX_A_LOW, 8'h55, 4'h0);
    for (int i = 0; i < 4; i++) begin
      rd_chk(10'(`SPOT_IDX_A_LOW + 2 * i), 8'(8'ha0 + i));
      rd_chk(10'(`SPOT_IDX_A_HIGH + 2 * i), 8'h3f);
    end
  endtask

  task automatic t_len;
    wr(`SPOT_IDX_A_LOW, 8'h03);
    wr(`SPOT_IDX_A_HIGH, 8'h00);
    wr(`SPOT_IDX_DIVISOR, 8'h02);
    wr(`SPOT_IDX_CTRL, 8'h01);
    phase(3 * P * 2);
    wr(`SPOT_IDX_A_LOW, 8'h01);
    wr(`SPOT_IDX_DIVISOR, 8'h00);
    phase(P * 256);
    wr(`SPOT_IDX_A_LOW, 8'h00);
    wr(`SPOT_IDX_DIVISOR, 8'h01);
    phase(16384 * P);
  endtask

  task automatic t_sel;
    wr(`SPOT_IDX_A_LOW, 8'h01);
    wr(`SPOT_IDX_A_HIGH, 8'h01);
    for (int i = 1; i < 4; i++) begin
      wr(10'(`SPOT_IDX_A_LOW + 2 * i), 8'(len[i]));
      wr(10'(`SPOT_IDX_A_HIGH + 2 * i), 8'h00);
    end
    for (int s = 0; s < 4; s++) begin
      wr(`SPOT_IDX_CTRL, 8'h00);
      @(posedge clk);
      `CHK(cfg, 2'h0)
      wr(`SPOT_IDX_CTRL, 8'(s * 4 + 1));
      for (int k = 0; k <= s + 1; k++) begin
        `CHK(cfg, 2'(k % (s + 1)))
        phase(len[k % (s + 1)] * P);
      end
    end
    rd_chk(`SPOT_IDX_STATUS, 8'h02);
    rd_chk(`SPOT_IDX_CTRL, 8'h0d);
    rd_chk(`SPOT_IDX_COUNT, 8'h00);
  endtask

  // Count and status inside a phase, then abort by clearing run
  task automatic t_mid;
    wr(`SPOT_IDX_A_LOW, 8'h05);
    wr(`SPOT_IDX_DIVISOR, 8'h10);
    wr(`SPOT_IDX_CTRL, 8'h01);
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    rd_chk(`SPOT_IDX_COUNT, 8'h05);
    rd_chk(`SPOT_IDX_STATUS, 8'h01);
    wr(`SPOT_IDX_CTRL, 8'h00);
    @(posedge clk);
    `CHK({act, done, cfg}, 4'h0)
  endtask

  // Reset in mid-phase: outputs quiet, registers back to reset values
  task automatic t_rst;
    wr(`SPOT_IDX_A_LOW, 8'h02);
    wr(`SPOT_IDX_DIVISOR, 8'h01);
    wr(`SPOT_IDX_CTRL, 8'h05);
    phase(2 * P);
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK({act, done, cfg}, 4'h0)
    rd_chk(`SPOT_IDX_A_LOW, `SPOT_RST_LOW);
    rd_chk(`SPOT_IDX_DIVISOR, `SPOT_RST_DIVISOR);
    rd_chk(`SPOT_IDX_CTRL, 8'h00);
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_len();
    t_mid();
    t_rst();
    t_sel();
    summarize();
  end
endmodule

bind spot_top spot_top_chk #(.PRESCALE(PRESCALE), .ADR_W(ADR_W)) u_chk (
  .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_WB_CYC(I_WB_CYC),
  .I_WB_STB(I_WB_STB), .I_ON_START(I_ON_START), .O_WB_ACK(O_WB_ACK),
  .O_WB_DAT(O_WB_DAT), .O_ON_ACTIVE(O_ON_ACTIVE), .O_ON_DONE(O_ON_DONE),
  .O_CFG_SEL(O_CFG_SEL));
